// File: core/cks_pkg.sv
// Constants for the key source selection block
package cks_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  ADDR_CFG   = 8'h00;
  localparam logic [7:0]  ADDR_CTL   = 8'h04;
  localparam logic [7:0]  ADDR_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_OTP   = 8'h0C;
  localparam logic [7:0]  ADDR_GO    = 8'h10;

  // ----------------------------------------
  // Configuration page fields
  // ----------------------------------------
  localparam int          CFG_RSV    = 31;
  localparam int          CFG_CONFIG_PROGRAMMED_FLAG = 30;
  localparam int          CFG_KT_LO  = 20;
  localparam int          CFG_SESSION_KEY_ENABLE = 19;
  localparam int          CFG_LKS_LO = 11;
  localparam int          CFG_KEY_SOURCE_LOCK = 10;
  localparam int          CFG_WRL_LO = 1;
  localparam int          CFG_SWKDIS = 0;
  localparam int          NUM_PAGES  = 9;

  // ----------------------------------------
  // Control, program control and status fields
  // ----------------------------------------
  localparam int          CTL_SRC_LO = 0;
  localparam int          CTL_MOD_LO = 4;
  localparam int          CTL_SESS   = 6;
  localparam int          CTL_W      = 7;
  localparam int          OTP_MIRROR = 7;
  localparam int          OTP_PG_LO  = 1;
  localparam int          OTP_WR     = 0;
  localparam int          ST_PFAIL   = 0;
  localparam int          ST_KFAIL   = 1;
  localparam int          ST_RAM     = 2;
  localparam int          ST_SW      = 3;
  localparam int          ST_SRC_LO  = 4;
  localparam int          ST_KEK     = 8;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [1:0]  MODE_DES   = 2'h0;
  localparam logic [1:0]  MODE_2DES  = 2'h1;
  localparam logic [1:0]  KT_DES     = 2'h0;
  localparam logic [3:0]  SRC_SW     = 4'h0;
  localparam logic [3:0]  LAST_PAGE  = 4'h8;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [6:0]  CTL_RST    = 7'h00;
  localparam logic [3:0]  PAGE_RST   = 4'h0;

  typedef enum logic [1:0] {
    CKS_PG_IDLE,
    CKS_PG_DONE,
    CKS_PG_FAIL
  } cks_pg_state_t;

endpackage

// File: core/cks_sel_if.sv
// Interface between key slot mapping and the top level
`timescale 1ns/1ps
`default_nettype none
interface cks_sel_if;
  logic [1:0] mode;
  logic [3:0] src;
  logic       sess;
  logic [1:0] kt12;
  logic       sw_dis;
  logic       err;
  logic       use_sw;
  logic       use_ram;
  logic       key1;
  logic [2:0] slot_a;
  logic [2:0] slot_b;

  modport map (input mode, src, sess, kt12, sw_dis,
               output err, use_sw, use_ram, key1, slot_a, slot_b);
  modport top (output mode, src, sess, kt12, sw_dis,
               input err, use_sw, use_ram, key1, slot_a, slot_b);
endinterface
`default_nettype wire

// File: core/cks_src_resolve.sv
// Effective key source: locked field or software selection
`timescale 1ns/1ps
`default_nettype none
module cks_src_resolve (
  // Configuration
  input  wire logic       lock,
  input  wire logic [7:0] locked_key_source_cfg,
  // Software selection
  input  wire logic [3:0] key_source_select,
  // Result
  output logic      [3:0] src
);

  // Highest set bit wins; bit 3 maps to 0100
  function automatic logic [3:0] cks_prio(input logic [7:0] f);
    casez (f)
      8'b1???????: cks_prio = 4'hF;
      8'b01??????: cks_prio = 4'h7;
      8'b001?????: cks_prio = 4'h6;
      8'b0001????: cks_prio = 4'h5;
      8'b00001???: cks_prio = 4'h4;
      8'b000001??: cks_prio = 4'h3;
      8'b0000001?: cks_prio = 4'h2;
      8'b00000001: cks_prio = 4'h1;
      default:     cks_prio = 4'h0;
    endcase
  endfunction

  // Lock ignores software; unlocked ignores the field
  wire logic [3:0] locked_src = cks_prio(locked_key_source_cfg); // see R3 R4 R5
  assign src = lock ? locked_src : key_source_select; // see R6 R7

endmodule
`default_nettype wire

// File: core/cks_slot_map.sv
// Maps key mode and source onto a key slot or an error
`timescale 1ns/1ps
`default_nettype none
module cks_slot_map (
  // Selection in, decision out
  cks_sel_if.map sel
);

  wire logic       is_sw  = (sel.src == cks_pkg::SRC_SW);
  wire logic       ram    = sel.src[3];
  wire logic [2:0] num    = sel.src[2:0];
  wire logic [2:0] num_m1 = num - 3'h1;
  wire logic       des    = (sel.mode == cks_pkg::MODE_DES);
  wire logic       dd     = (sel.mode == cks_pkg::MODE_2DES);

  // Legal slot ranges per mode; 1000 and 1111 in pairs fall out
  wire logic des_ok = des && (num != 3'h0); // see R11
  wire logic dd_ok  = dd && (num != 3'h0) && (num <= 3'h4); // see R12

  // Pairs occupy two consecutive 64-bit slots
  assign sel.slot_a = des ? num_m1 : {num_m1[1:0], 1'b0}; // see R11 R12
  assign sel.slot_b = des ? num_m1 : {num_m1[1:0], 1'b1}; // see R12

  // OTP slots 0 and 1 live in pages 1 and 2
  wire logic p12 = !is_sw && !ram && (sel.slot_a[2:1] == 2'h0);
  wire logic type_bad = p12 && (sel.kt12 != cks_pkg::KT_DES); // see R1
  assign sel.key1 = !ram && (num == 3'h1);

  wire logic src_bad = is_sw ? sel.sw_dis : !(des_ok || dd_ok); // see R9 R13
  assign sel.err = !(des || dd) || src_bad || type_bad
                 || (sel.key1 && sel.sess); // see R13
  assign sel.use_sw  = is_sw && !sel.err; // see R10
  assign sel.use_ram = ram && !sel.err;

endmodule
`default_nettype wire

// File: core/cks_top.sv
// Key source selection and key configuration checking
// Behaviour
// R1: Pages 1-2 key type other than DES/2DES forbids their keys here.
// R2: With session key enable, stored key 1 serves only as key encryption key.
// R3: Locked field bits 7..4 highest set give sources 1111, 0111, 0110, 0101.
// R4: Bits 2, 1, 0 give 0011, 0010, 0001; all zero gives 0000.
// R5: Bit 3 highest set gives source 0100.
// R6: Source lock set: locked field decides, software selection ignored.
// R7: Source lock clear: software selection decides, locked field ignored.
// R8: A set write lock bit forbids programming that page, pages 0 to 8.
// R9: Software key disabled with source 0000 fails and refuses operation starts.
// R10: Software key enabled: source 0000 picks the software key register.
// R11: DES: 0000 software, 0001-0111 OTP, 1001-1111 RAM slots.
// R12: 2-key mode: source picks two consecutive slots, 0001-0100 or 1001-1100.
// R13: Fail flag on bad code, 1111 pairs, mode 10, key 1 with session select.
// R14: Configuration programmed bit mirrored into program control register.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cks_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Key choice to the cipher datapath
  output logic             key_use_sw,
  output logic             key_use_ram,
  output logic      [2:0]  key_slot_a,
  output logic      [2:0]  key_slot_b,
  output logic             key_kek_only,
  output logic             key_config_fail_flag,
  // Operation and programming requests
  output logic             op_start,
  output logic             prog_go,
  output logic      [3:0]  prog_page
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [31:0]         cfg_reg;
  logic [31:0]         cfg_next;
  logic [6:0]          ctl_reg;
  logic [6:0]          ctl_next;
  logic [3:0]          page_reg;
  logic [3:0]          page_next;
  logic                fail_reg;
  logic                use_sw_reg;
  logic                use_ram_reg;
  logic [2:0]          slot_a_reg;
  logic [2:0]          slot_b_reg;
  logic                kek_reg;
  logic                start_reg;
  logic                start_next;
  logic                go_reg;
  logic                go_next;
  logic [3:0]          src_reg;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  cks_pkg::cks_pg_state_t pg_state;
  cks_pkg::cks_pg_state_t pg_next;

  // ----------------------------------------
  // Configuration page fields
  // ----------------------------------------
  wire logic [1:0] key_type_pages_1_2    = cfg_reg[cks_pkg::CFG_KT_LO +: 2];
  wire logic       session_key_enable    = cfg_reg[cks_pkg::CFG_SESSION_KEY_ENABLE];
  wire logic [7:0] locked_key_source_cfg = cfg_reg[cks_pkg::CFG_LKS_LO +: 8];
  wire logic       key_source_lock       = cfg_reg[cks_pkg::CFG_KEY_SOURCE_LOCK];
  wire logic [8:0] page_write_lock       = cfg_reg[cks_pkg::CFG_WRL_LO +: 9];
  wire logic       software_key_disable  = cfg_reg[cks_pkg::CFG_SWKDIS];
  wire logic       config_programmed_flag = cfg_reg[cks_pkg::CFG_CONFIG_PROGRAMMED_FLAG];

  // Control fields
  wire logic [3:0] key_source_select  = ctl_reg[cks_pkg::CTL_SRC_LO +: 4];
  wire logic [1:0] key_mode_select    = ctl_reg[cks_pkg::CTL_MOD_LO +: 2];
  wire logic       session_key_select = ctl_reg[cks_pkg::CTL_SESS];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic wr_cfg = wr && (addr == cks_pkg::ADDR_CFG);
  wire logic wr_ctl = wr && (addr == cks_pkg::ADDR_CTL);
  wire logic wr_otp = wr && (addr == cks_pkg::ADDR_OTP);
  wire logic wr_go  = wr && (addr == cks_pkg::ADDR_GO);

  // ----------------------------------------
  // Source resolution and slot mapping
  // ----------------------------------------
  logic [3:0] eff_src;
  cks_sel_if  sel_bus ();

  cks_src_resolve u_resolve (
    .lock                  (key_source_lock),
    .locked_key_source_cfg (locked_key_source_cfg),
    .key_source_select     (key_source_select),
    .src                   (eff_src)
  );

  assign sel_bus.mode   = key_mode_select;
  assign sel_bus.src    = eff_src;
  assign sel_bus.sess   = session_key_select;
  assign sel_bus.kt12   = key_type_pages_1_2;
  assign sel_bus.sw_dis = software_key_disable;

  cks_slot_map u_map (
    .sel (sel_bus)
  );

  // Stored key 1 under session key enable: key wrapping only
  wire logic kek_now = session_key_enable && sel_bus.key1 && !sel_bus.err; // see R2

  // ----------------------------------------
  // Page programming check
  // ----------------------------------------
  // Write lock of a page, reserved pages always refuse
  function automatic logic cks_page_bad(input logic [3:0] pg, input logic [8:0] lk);
    cks_page_bad = (pg > cks_pkg::LAST_PAGE) || lk[pg];
  endfunction

  wire logic [3:0] wr_page  = wdata[cks_pkg::OTP_PG_LO +: 4];
  wire logic       pg_req   = wr_otp && wdata[cks_pkg::OTP_WR];
  wire logic       pg_bad   = cks_page_bad(wr_page, page_write_lock); // see R8
  wire logic       pfail    = cks_page_bad(page_reg, page_write_lock); // see R8
  wire logic       cfg_ok   = !page_write_lock[0]; // see R8

  // Program once: set bits stay set, reserved bit untouched
  wire logic [31:0] cfg_prog = cfg_reg | (wdata & ~(32'h1 << cks_pkg::CFG_RSV));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Page 0 write is direct programming of the configuration
  assign cfg_next   = (wr_cfg && cfg_ok) ? cfg_prog : cfg_reg; // see R8
  assign ctl_next   = wr_ctl ? wdata[cks_pkg::CTL_W-1:0] : ctl_reg;
  assign page_next  = wr_otp ? wr_page : page_reg;
  assign go_next    = pg_req && !pg_bad; // see R8
  // Start refused while configuration is bad, no queueing
  assign start_next = wr_go && wdata[0] && !sel_bus.err; // see R9

  // Program result kept for readback in the program control register
  always_comb begin
    case (pg_state)
      cks_pkg::CKS_PG_IDLE,
      cks_pkg::CKS_PG_DONE,
      cks_pkg::CKS_PG_FAIL: begin
        if (pg_req) begin
          pg_next = pg_bad ? cks_pkg::CKS_PG_FAIL : cks_pkg::CKS_PG_DONE;
        end else begin
          pg_next = pg_state;
        end
      end
      default: pg_next = cks_pkg::CKS_PG_IDLE;
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [31:0] stat_word = {23'h0,
                                 kek_reg,
                                 src_reg,
                                 use_sw_reg,
                                 use_ram_reg,
                                 fail_reg,
                                 pfail};
  wire logic [31:0] otp_word  = {24'h0,
                                 config_programmed_flag, // see R14
                                 1'b0,
                                 pg_state == cks_pkg::CKS_PG_FAIL,
                                 page_reg,
                                 1'b0};

  // Unmapped offsets read zero
  always_comb begin
    case (addr)
      cks_pkg::ADDR_CFG:  rdata_next = cfg_reg;
      cks_pkg::ADDR_CTL:  rdata_next = {25'h0, ctl_reg};
      cks_pkg::ADDR_STAT: rdata_next = stat_word;
      cks_pkg::ADDR_OTP:  rdata_next = otp_word;
      default:            rdata_next = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Software visible state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_reg  <= cks_pkg::CFG_RST;
      ctl_reg  <= cks_pkg::CTL_RST;
      page_reg <= cks_pkg::PAGE_RST;
      pg_state <= cks_pkg::CKS_PG_IDLE;
    end else begin
      cfg_reg  <= cfg_next;
      ctl_reg  <= ctl_next;
      page_reg <= page_next;
      pg_state <= pg_next;
    end
  end

  // Key decision, one cycle behind the selection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fail_reg    <= 1'b0;
      use_sw_reg  <= 1'b0;
      use_ram_reg <= 1'b0;
      slot_a_reg  <= 3'h0;
      slot_b_reg  <= 3'h0;
      kek_reg     <= 1'b0;
      src_reg     <= 4'h0;
    end else begin
      fail_reg    <= sel_bus.err; // see R13
      use_sw_reg  <= sel_bus.use_sw; // see R10
      use_ram_reg <= sel_bus.use_ram; // see R11
      slot_a_reg  <= sel_bus.slot_a;
      slot_b_reg  <= sel_bus.slot_b;
      kek_reg     <= kek_now; // see R2
      src_reg     <= eff_src;
    end
  end

  // Pulses and read data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      go_reg    <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      start_reg <= start_next;
      go_reg    <= go_next;
      rdata_reg <= rd ? rdata_next : 32'h0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata                = rdata_reg;
  assign key_use_sw           = use_sw_reg;
  assign key_use_ram          = use_ram_reg;
  assign key_slot_a           = slot_a_reg;
  assign key_slot_b           = slot_b_reg;
  assign key_kek_only         = kek_reg;
  assign key_config_fail_flag = fail_reg;
  assign op_start             = start_reg;
  assign prog_go              = go_reg;
  assign prog_page            = page_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Single clock domain; reset disables every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_kt_restrict: assert property ( // see R1
    (key_type_pages_1_2 != cks_pkg::KT_DES && !eff_src[3] && eff_src[2:1] == 2'h0
     && eff_src[0] && key_mode_select == cks_pkg::MODE_DES) |=> key_config_fail_flag)
    else $error("pages 1-2 key type not enforced");

  chk_kek_only: assert property ( // see R2
    key_kek_only |-> $past(session_key_enable) && $past(eff_src) == 4'h1)
    else $error("key encryption only flag without cause");

  chk_lock_prio_hi: assert property ( // see R3
    (key_source_lock && locked_key_source_cfg[7]) |-> eff_src == 4'hF)
    else $error("locked bit 7 did not select 1111");

  chk_lock_prio_lo: assert property ( // see R4 R5
    (key_source_lock && locked_key_source_cfg[7:3] == 5'h01) |-> eff_src == 4'h4)
    else $error("locked bit 3 did not select 0100");

  chk_lock_zero: assert property ( // see R4
    (key_source_lock && locked_key_source_cfg == 8'h00) |-> eff_src == 4'h0)
    else $error("empty locked field did not select 0000");

  chk_sw_ignored: assert property ( // see R6 R7
    key_source_lock ? eff_src == $past(eff_src) || $changed(cfg_reg)
                    : eff_src == key_source_select)
    else $error("source lock not respected");

  chk_page_lock: assert property ( // see R8
    (pg_req && page_write_lock[wr_page]) |=> !prog_go)
    else $error("locked page was programmed");

  chk_cfg_locked: assert property ( // see R8
    (wr_cfg && page_write_lock[0]) |=> $stable(cfg_reg))
    else $error("locked configuration page changed");

  chk_swdis_fail: assert property ( // see R9
    (software_key_disable && eff_src == cks_pkg::SRC_SW) |=> key_config_fail_flag && !op_start)
    else $error("disabled software key accepted");

  // Sampled reset keeps the release edge out: registers still reset there
  chk_sw_select: assert property ( // see R10
    (rst_n && !software_key_disable && eff_src == cks_pkg::SRC_SW
     && key_mode_select == cks_pkg::MODE_DES) |=> key_use_sw && !key_config_fail_flag)
    else $error("software key not selected");

  chk_des_slot: assert property ( // see R11
    (key_mode_select == cks_pkg::MODE_DES && eff_src[2:0] != 3'h0 && !key_config_fail_flag)
    ##0 (1'b1) |=> (key_config_fail_flag || key_slot_a == $past(eff_src[2:0]) - 3'h1))
    else $error("DES slot wrong");

  chk_pair_slot: assert property ( // see R12
    (!key_config_fail_flag && $past(key_mode_select) == cks_pkg::MODE_2DES)
    |-> key_slot_b == key_slot_a + 3'h1 && !key_slot_a[0])
    else $error("pair slots not consecutive");

  chk_mode_fail: assert property ( // see R13
    (key_mode_select[1] || (eff_src == 4'h1 && session_key_select))
    |=> key_config_fail_flag [*1])
    else $error("bad configuration not flagged");

  // Read back, not the word itself, so the read mux is covered too
  chk_mirror: assert property ( // see R14
    (rd && addr == cks_pkg::ADDR_OTP)
    |=> rdata[cks_pkg::OTP_MIRROR] == $past(config_programmed_flag))
    else $error("program test mirror differs");

  chk_prog_ok: assert property ( // see R8
    (pg_req && wr_page <= cks_pkg::LAST_PAGE && !page_write_lock[wr_page]) |=> prog_go)
    else $error("unlocked page not programmed");

  chk_pair_rsv: assert property ( // see R13
    (key_mode_select == cks_pkg::MODE_2DES && eff_src == 4'hF) |=> key_config_fail_flag)
    else $error("reserved pair source not flagged");

  // Main scenarios the bench should reach
  cov_start_ok:  cover property (wr_go ##1 op_start);
  cov_locked_src: cover property (key_source_lock && eff_src == 4'h7 ##1 key_use_ram == 1'b0);
  cov_pair_ram:  cover property (key_use_ram && $past(key_mode_select) == cks_pkg::MODE_2DES);
  cov_prog_fail: cover property (pg_req && pg_bad ##1 pg_state == cks_pkg::CKS_PG_FAIL);
  cov_kek_only:  cover property (key_kek_only);

endmodule
`default_nettype wire

// File: test/cks_top_tb_top.sv
// Self-checking bench for the key source selection block
`timescale 1ns/1ps
`default_nettype none
module cks_top_tb_top;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic        mclk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        key_use_sw;
  logic        key_use_ram;
  logic [2:0]  key_slot_a;
  logic [2:0]  key_slot_b;
  logic        key_kek_only;
  logic        key_config_fail_flag;
  logic        op_start;
  logic        prog_go;
  logic [3:0]  prog_page;
  int          miscompares;
  int          samples_checked;
  int          starts;
  int          progs;
  int          cycles;
  logic [31:0] cfg_m;
  logic [31:0] v;
  logic        e_fail, e_sw, e_ram, e_kek;
  logic [2:0]  e_a, e_b;
  logic [3:0]  e_src;

  cks_top dut (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .key_use_sw           (key_use_sw),
    .key_use_ram          (key_use_ram),
    .key_slot_a           (key_slot_a),
    .key_slot_b           (key_slot_b),
    .key_kek_only         (key_kek_only),
    .key_config_fail_flag (key_config_fail_flag),
    .op_start             (op_start),
    .prog_go              (prog_go),
    .prog_page            (prog_page)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Pulse counters; a hang is cut short by the cycle ceiling
  always @(posedge mclk) begin
    if (op_start === 1'b1) starts++;
    if (prog_go === 1'b1) progs++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    cfg_m = 32'h0000_0000;
  endtask

  // Config page is program-once: bits only ever gain ones, bit 31 never
  task automatic prog_cfg(input logic [31:0] d);
    bus_wr(cks_pkg::ADDR_CFG, d);
    cfg_m = cfg_m | (d & 32'h7FFF_FFFF);
  endtask

  // Expected key choice from the configuration model
  task automatic expect_key(input logic [1:0] mode, input logic [3:0] sel, input logic sess);
    logic [3:0] s;
    s = sel;
    if (cfg_m[10]) begin
      s = 4'h0;
      for (int b = 0; b < 8; b++) if (cfg_m[11 + b]) s = (b == 7) ? 4'hF : 4'(b + 1);
    end
    e_src = s;
    e_sw = (s == 4'h0);
    e_ram = s[3];
    e_a = (mode == 2'h1) ? {s[1:0] - 2'h1, 1'b0} : s[2:0] - 3'h1;
    e_b = (mode == 2'h1) ? e_a + 3'h1 : e_a;
    e_fail = mode[1] | (e_sw & cfg_m[0]) | (sess & s == 4'h1);
    if (!e_sw) e_fail |= (s[2:0] == 3'h0) | (mode == 2'h1 & s[2:0] > 3'h4);
    if (!e_sw & !s[3] & cfg_m[21:20] != 2'h0 & e_a <= 3'h1) e_fail = 1'b1;
    e_kek = (s == 4'h1) & cfg_m[19] & !e_fail;
  endtask

  task automatic check_key(input logic [1:0] mode, input logic [3:0] sel, input logic sess);
    int n0;
    expect_key(mode, sel, sess);
    bus_wr(cks_pkg::ADDR_CTL, {25'h0, sess, mode, sel});
    repeat (3) @(posedge mclk);
    #1;
    chk("fail flag", 32'(e_fail), 32'(key_config_fail_flag));
    if (!e_fail) begin
      chk("key choice", 32'({e_sw, e_ram, e_kek}),
          32'({key_use_sw, key_use_ram, key_kek_only}));
      if (!e_sw) chk("slots", 32'({e_a, e_b}), 32'({key_slot_a, key_slot_b}));
    end
    bus_rd(cks_pkg::ADDR_STAT, v);
    chk("status", 32'({e_kek, e_src, e_sw & !e_fail, e_ram & !e_fail, e_fail}),
        32'(v[8:1]));
    n0 = starts;
    bus_wr(cks_pkg::ADDR_GO, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk("op starts", 32'(!e_fail), 32'(starts - n0));
  endtask

  task automatic prog_page_req(input logic [3:0] p, input logic ok);
    int n0;
    n0 = progs;
    bus_wr(cks_pkg::ADDR_OTP, {27'h0, p, 1'b1});
    repeat (2) @(posedge mclk);
    chk("program pulses", 32'(ok), 32'(progs - n0));
    if (ok) chk("page", 32'(p), 32'(prog_page));
    bus_rd(cks_pkg::ADDR_OTP, v);
    chk("refused bit", 32'(!ok), 32'(v[5]));
    bus_rd(cks_pkg::ADDR_STAT, v);
    chk("page fail", 32'(!ok), 32'(v[0]));
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    starts = 0;
    progs = 0;
    cycles = 0;
    do_reset();
    // Reset values and an unmapped address
    bus_rd(cks_pkg::ADDR_CFG, v);
    chk("config reset", 32'h0000_0000, v);
    bus_rd(cks_pkg::ADDR_CTL, v);
    chk("control reset", 32'h0000_0000, v);
    bus_rd(8'h14, v);
    chk("unmapped", 32'h0000_0000, v);
    // Every mode and source code, then session select cases
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 16; s++) begin
        check_key(2'(m), 4'(s), 1'b0);
      end
    end
    check_key(2'h0, 4'h1, 1'b1);
    check_key(2'h1, 4'h1, 1'b1);
    check_key(2'h0, 4'h9, 1'b1);
    // Software key disabled and session key enable; bit 31 not writable
    prog_cfg(32'h8008_0001);
    bus_rd(cks_pkg::ADDR_CFG, v);
    chk("config page", cfg_m, v);
    check_key(2'h0, 4'h0, 1'b0);
    check_key(2'h0, 4'h1, 1'b0);
    check_key(2'h1, 4'h1, 1'b0);
    // Pages 1-2 key type 01 with locked field set but no source lock
    prog_cfg(32'h0017_F800);
    for (int s = 0; s < 4; s++) check_key(2'h0, 4'(s), 1'b0);
    check_key(2'h1, 4'h1, 1'b0);
    check_key(2'h1, 4'h2, 1'b0);
    check_key(2'h0, 4'h9, 1'b0);
    // Source lock: priority encoder, growing the field one bit at a time
    do_reset();
    for (int i = 0; i < 9; i++) begin
      prog_cfg(32'h0000_0400 | (((32'h1 << i) - 32'h1) << 11));
      check_key(2'h0, 4'hA, 1'b0);
    end
    // Page programming, mirror bit, write locks
    do_reset();
    for (int p = 0; p < 10; p++) prog_page_req(4'(p), p < 9);
    prog_cfg(32'h4000_0000);
    bus_rd(cks_pkg::ADDR_OTP, v);
    chk("mirror", 32'h1, 32'(v[7]));
    prog_cfg(32'h0000_0012);
    prog_page_req(4'h3, 1'b0);
    prog_page_req(4'h4, 1'b1);
    prog_page_req(4'h0, 1'b0);
    bus_wr(cks_pkg::ADDR_CFG, 32'h0000_0001);
    bus_rd(cks_pkg::ADDR_CFG, v);
    chk("locked config", cfg_m, v);
    conclude();
  end
endmodule
`default_nettype wire
